// *** usf_defines.svh ***
`ifndef USF_DEFINES_SVH
`define USF_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define USF_OFF_DATA    4'h0
`define USF_OFF_STATUS  4'h4
`define USF_OFF_CONTROL 4'h8
`define USF_OFF_FORMAT  4'hc

// ------------------------------------------------------------
// status register bit positions
// ------------------------------------------------------------
`define USF_ST_RXC  7
`define USF_ST_TXC  6
`define USF_ST_UDRE 5
`define USF_ST_FE   4
`define USF_ST_DOR  3
`define USF_ST_PE   2

// ------------------------------------------------------------
// control register bit positions
// ------------------------------------------------------------
`define USF_CT_RXCIE 7
`define USF_CT_TXCIE 6
`define USF_CT_UDRIE 5
`define USF_CT_RXEN  4
`define USF_CT_TRANSMIT_ENABLE_BIT  3
`define USF_CT_RXB8  1
`define USF_CT_TXB8  0
`define USF_CT_WMASK 8'hf9

// ------------------------------------------------------------
// frame format register fields
// ------------------------------------------------------------
`define USF_FM_PAR_EN  5
`define USF_FM_PAR_ODD 4
`define USF_FM_STOP2   3
`define USF_FM_SIZE    2:0
`define USF_FM_WMASK   8'h3f
`define USF_SIZE_9BIT  3'h7
`define USF_SIZE_MAXN  3'h3

// ------------------------------------------------------------
// reset values and bus answers
// ------------------------------------------------------------
`define USF_CTRL_RST   8'h00
`define USF_FMT_RST    8'h03
`define USF_RESP_OKAY  2'h0
`define USF_RESP_SLV   2'h2
`define USF_FRAME_W    13
`define USF_FIFO_FULL  2'h2

`endif

// *** usf_pkg.sv ***
package usf_pkg;
	// transmit shifter states
	typedef enum logic {USF_TX_IDLE, USF_TX_SHIFT} usf_tx_state_t;
	// receive shifter states
	typedef enum logic {USF_RX_IDLE, USF_RX_DATA} usf_rx_state_t;
endpackage

// *** usf_uart_flags.sv ***
// Overview of operation
// - buffer-empty high exactly while tx buffer empty
// - empty irq requested while flag high, enabled
// - data write loads buffer, clears empty flag
// - complete flag sets when frame out, buffer empty
// - complete flag clears on service or write-one
// - complete irq requested when flag sets, enabled
// - parity bit inserted before first stop bit
// - parity is xor of data, inverted if odd
// - tx disable waits for drain, then releases pin
// - receive enable takes over the input pin
// - sample bits after start; ignore second stop
// - first stop moves frame into receive buffer
// - unused upper data bits read as zero
// - ninth bit, errors stored per fifo entry
// - receive-complete flag shows unread data present
// - receive disable flushes the receive buffer
// - receive irq requested while flag set, enabled
// - error flags ignore writes, raise no irq
// - frame error means first stop sampled zero
// - overrun: fifo full, char waiting, new start
// - overrun flag clears on successful move
// - parity error per frame, zero when disabled
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "usf_defines.svh"

module usf_uart_flags
(
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        bit_tick,
	input  wire logic        serial_in_pin,
	output logic             rx_pin_owned,
	output logic             serial_out_pin,
	output logic             serial_out_oe,
	input  wire logic        global_irq_enable,
	input  wire logic        txc_irq_ack,
	output logic             irq_tx_empty,
	output logic             irq_tx_complete,
	output logic             irq_rx_complete
);

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// number of data bits for a size code
	function automatic logic [3:0] fn_data_bits(input logic [2:0] size);
		if (size == `USF_SIZE_9BIT)
			return 4'h9;
		else if (size <= `USF_SIZE_MAXN)
			return 4'(size) + 4'h5;
		else
			return 4'h8;
	endfunction

	// parity over the low n data bits
	function automatic logic fn_parity(input logic [8:0] d, input logic [3:0] n,
		input logic odd);
		logic p;
		p = odd;
		for (int i = 0; i < 9; i++)
			if (4'(i) < n)
				p = p ^ d[i];
		return p;
	endfunction

	// keep only the low n data bits
	function automatic logic [8:0] fn_mask(input logic [8:0] d, input logic [3:0] n);
		logic [8:0] m;
		m = '0;
		for (int i = 0; i < 9; i++)
			if (4'(i) < n)
				m[i] = d[i];
		return m;
	endfunction

	// ------------------------------------------------------------
	// registers and state
	// ------------------------------------------------------------
	logic [7:0]  ctrl_r;                 // software control bits
	logic [7:0]  fmt_r;                  // frame format bits
	logic        aw_held_r, w_held_r;    // write halves captured
	logic [3:0]  aw_addr_r;              // captured write address
	logic [31:0] w_data_r;               // captured write data
	logic        w_strb_r;               // low byte lane enabled
	logic        bvalid_r, rvalid_r;     // response pending
	logic [1:0]  bresp_r, rresp_r;       // response codes
	logic [31:0] rdata_r;                // read data
	usf_pkg::usf_tx_state_t tx_state_r;  // transmit shifter state
	logic        tx_buf_valid_r;         // transmit buffer holds a char
	logic [8:0]  tx_buf_r;               // transmit buffer
	logic [12:0] tx_sh_r;                // frame shift register
	logic [3:0]  tx_left_r;              // bits left in frame
	logic        txc_r;                  // transmit complete flag
	logic        tx_on_r;                // effective transmit enable
	usf_pkg::usf_rx_state_t rx_state_r;  // receive shifter state
	logic [12:0] rx_bits_r;              // receive shift register
	logic [3:0]  rx_idx_r;               // bits taken so far
	logic        rx_hold_r;              // finished frame waits
	logic [10:0] rx_hold_e_r;            // {pe, fe, data} waiting
	logic        dor_pend_r;             // overrun seen, not yet moved
	logic [11:0] fifo_mem [2];           // {dor, pe, fe, data}
	logic        fifo_rd_r;              // read slot
	logic [1:0]  fifo_cnt_r;             // entries held

	// ------------------------------------------------------------
	// decoding
	// ------------------------------------------------------------
	wire       par_en      = fmt_r[`USF_FM_PAR_EN];
	wire       par_odd     = fmt_r[`USF_FM_PAR_ODD];
	wire [3:0] n_bits      = fn_data_bits(fmt_r[`USF_FM_SIZE]);
	wire       rx_en       = ctrl_r[`USF_CT_RXEN];
	wire       wr_go       = aw_held_r && w_held_r && !bvalid_r;
	wire       wr_ok       = (aw_addr_r[1:0] == 2'h0);
	wire       wr_act      = wr_go && wr_ok && w_strb_r;
	wire       wr_data     = wr_act && (aw_addr_r == `USF_OFF_DATA);
	wire       wr_status   = wr_act && (aw_addr_r == `USF_OFF_STATUS);
	wire       wr_ctrl     = wr_act && (aw_addr_r == `USF_OFF_CONTROL);
	wire       wr_fmt      = wr_act && (aw_addr_r == `USF_OFF_FORMAT);
	wire       rd_go       = s_axi_arvalid && s_axi_arready;
	wire       rd_ok       = (s_axi_araddr[1:0] == 2'h0);
	wire       rxc         = (fifo_cnt_r != 2'h0);
	wire       pop         = rd_go && (s_axi_araddr == `USF_OFF_DATA) && rxc;
	wire       fifo_full   = (fifo_cnt_r == `USF_FIFO_FULL);
	wire       push        = rx_en && rx_hold_r && (!fifo_full || pop);
	wire       wr_idx      = fifo_rd_r ^ fifo_cnt_r[0];
	wire [11:0] head       = fifo_mem[fifo_rd_r];
	wire       udre        = !tx_buf_valid_r;
	wire       pe_vis      = head[10] && par_en && rxc;
	wire       fe_vis      = head[9] && rxc;
	wire       dor_vis     = head[11] && rxc;
	wire [7:0] status_w    = {rxc, txc_r, udre, fe_vis, dor_vis, pe_vis, 2'h0};
	wire [7:0] ctrl_rd     = {ctrl_r[7:2], head[8] && rxc, ctrl_r[`USF_CT_TXB8]};

	// ------------------------------------------------------------
	// bus slave: write channel
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready  = !w_held_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;

	// address and data are taken in either order, answered together
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			aw_addr_r <= 4'h0;
			w_data_r  <= 32'h0;
			w_strb_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `USF_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb[0];
			end
			if (wr_go)
			begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_ok ? `USF_RESP_OKAY : `USF_RESP_SLV;
			end
			else if (s_axi_bready)
				bvalid_r <= 1'b0;
		end
	end

	// control and format registers; error flags are not writable
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			ctrl_r <= `USF_CTRL_RST;
			fmt_r  <= `USF_FMT_RST;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= w_data_r[7:0] & `USF_CT_WMASK;
			if (wr_fmt)
				fmt_r <= w_data_r[7:0] & `USF_FM_WMASK;
		end
	end

	// ------------------------------------------------------------
	// bus slave: read channel
	// ------------------------------------------------------------
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	// reading data pops the fifo, so status must be read first
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0;
			rresp_r  <= `USF_RESP_OKAY;
		end
		else if (rd_go)
		begin
			rvalid_r <= 1'b1;
			rresp_r  <= rd_ok ? `USF_RESP_OKAY : `USF_RESP_SLV;
			case (s_axi_araddr)
				`USF_OFF_DATA:    rdata_r <= {24'h0, rxc ? head[7:0] : 8'h0};
				`USF_OFF_STATUS:  rdata_r <= {24'h0, status_w};
				`USF_OFF_CONTROL: rdata_r <= {24'h0, ctrl_rd};
				`USF_OFF_FORMAT:  rdata_r <= {24'h0, fmt_r};
				default:          rdata_r <= 32'h0;
			endcase
		end
		else if (s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// transmitter
	// ------------------------------------------------------------
	wire        tx_par   = fn_parity(tx_buf_r, n_bits, par_odd);
	wire [3:0]  tx_len   = 4'h2 + n_bits + {3'h0, par_en} + {3'h0, fmt_r[`USF_FM_STOP2]};
	wire        tx_load  = (tx_state_r == usf_pkg::USF_TX_IDLE) && tx_buf_valid_r && tx_on_r;
	wire        tx_done  = (tx_state_r == usf_pkg::USF_TX_SHIFT) && bit_tick
	                       && (tx_left_r == 4'h1);
	wire        tx_busy  = (tx_state_r == usf_pkg::USF_TX_SHIFT) || tx_buf_valid_r;
	logic [12:0] tx_frame;

	// start bit, data lsb first, parity, then stop bits (idle ones)
	always_comb
	begin
		tx_frame = '1;
		tx_frame[0] = 1'b0;
		for (int i = 0; i < 9; i++)
		begin
			if (4'(i) < n_bits)
				tx_frame[i + 1] = tx_buf_r[i];
		end
		// parity right after the last data bit, nine-bit frames included
		if (par_en)
			tx_frame[n_bits + 4'h1] = tx_par;
	end

	// buffer, shifter and delayed disable; first bit runs to the next tick
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			tx_state_r     <= usf_pkg::USF_TX_IDLE;
			tx_buf_valid_r <= 1'b0;
			tx_buf_r       <= 9'h0;
			tx_sh_r        <= '1;
			tx_left_r      <= 4'h0;
			tx_on_r        <= 1'b0;
		end
		else
		begin
			tx_on_r <= ctrl_r[`USF_CT_TRANSMIT_ENABLE_BIT] || (tx_on_r && tx_busy);
			if (wr_data)
			begin
				tx_buf_valid_r <= 1'b1;
				tx_buf_r       <= {ctrl_r[`USF_CT_TXB8], w_data_r[7:0]};
			end
			else if (tx_load)
				tx_buf_valid_r <= 1'b0;
			case (tx_state_r)
				usf_pkg::USF_TX_IDLE:
				begin
					if (tx_load)
					begin
						tx_sh_r    <= tx_frame;
						tx_left_r  <= tx_len;
						tx_state_r <= usf_pkg::USF_TX_SHIFT;
					end
				end
				usf_pkg::USF_TX_SHIFT:
				begin
					if (bit_tick)
					begin
						tx_sh_r   <= {1'b1, tx_sh_r[12:1]};
						tx_left_r <= tx_left_r - 4'h1;
						if (tx_left_r == 4'h1)
							tx_state_r <= usf_pkg::USF_TX_IDLE;
					end
				end
				default: tx_state_r <= usf_pkg::USF_TX_IDLE;
			endcase
		end
	end

	// complete flag: a set in the same cycle as a clear wins
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			txc_r <= 1'b0;
		else if (tx_done && !tx_buf_valid_r)
			txc_r <= 1'b1;
		else if (txc_irq_ack || (wr_status && w_data_r[`USF_ST_TXC]))
			txc_r <= 1'b0;
	end

	assign serial_out_pin = tx_sh_r[0];
	assign serial_out_oe  = tx_on_r;

	// ------------------------------------------------------------
	// receiver
	// ------------------------------------------------------------
	wire [3:0]  rx_len   = n_bits + {3'h0, par_en} + 4'h1;
	wire [12:0] rx_shift = {serial_in_pin, rx_bits_r[12:1]};
	wire [12:0] rx_frame = rx_shift >> (4'(`USF_FRAME_W) - rx_len);
	wire [8:0]  rx_data  = fn_mask(rx_frame[8:0], n_bits);
	wire        rx_pbit  = rx_frame[n_bits];
	wire        rx_stop  = rx_frame[rx_len - 4'h1];
	wire        rx_start = (rx_state_r == usf_pkg::USF_RX_IDLE) && rx_en && bit_tick
	                       && !serial_in_pin;
	wire        rx_last  = (rx_state_r == usf_pkg::USF_RX_DATA) && bit_tick
	                       && (rx_idx_r == rx_len - 4'h1);
	wire        rx_pe    = par_en && (fn_parity(rx_data, n_bits, par_odd) != rx_pbit);
	wire        ovr_set  = rx_start && rx_hold_r && fifo_full && !pop;

	assign rx_pin_owned = rx_en;

	// shifter stops at the first stop bit; a second one is just idle line
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b || !rx_en)
		begin
			rx_state_r  <= usf_pkg::USF_RX_IDLE;
			rx_bits_r   <= 13'h0;
			rx_idx_r    <= 4'h0;
			rx_hold_r   <= 1'b0;
			rx_hold_e_r <= 11'h0;
		end
		else
		begin
			if (push)
				rx_hold_r <= 1'b0;
			case (rx_state_r)
				usf_pkg::USF_RX_IDLE:
				begin
					if (rx_start)
					begin
						rx_idx_r   <= 4'h0;
						rx_state_r <= usf_pkg::USF_RX_DATA;
					end
				end
				usf_pkg::USF_RX_DATA:
				begin
					if (bit_tick)
					begin
						rx_bits_r <= rx_shift;
						rx_idx_r  <= rx_idx_r + 4'h1;
					end
					if (rx_last)
					begin
						rx_hold_r   <= 1'b1;
						rx_hold_e_r <= {rx_pe, !rx_stop, rx_data};
						rx_state_r  <= usf_pkg::USF_RX_IDLE;
					end
				end
				default: rx_state_r <= usf_pkg::USF_RX_IDLE;
			endcase
		end
	end

	// overrun pending until the next successful move into the fifo
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b || !rx_en)
			dor_pend_r <= 1'b0;
		else if (ovr_set)
			dor_pend_r <= 1'b1;
		else if (push)
			dor_pend_r <= 1'b0;
	end

	// two-entry fifo; each entry carries its own ninth bit and errors
	always_ff @(posedge ref_clk)
	begin
		if (push)
			fifo_mem[wr_idx] <= {dor_pend_r, rx_hold_e_r};
	end

	// fifo pointers; disabling the receiver empties it at once
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b || !rx_en)
		begin
			fifo_rd_r  <= 1'b0;
			fifo_cnt_r <= 2'h0;
		end
		else
		begin
			if (pop)
				fifo_rd_r <= !fifo_rd_r;
			case ({push, pop})
				2'b10:   fifo_cnt_r <= fifo_cnt_r + 2'h1;
				2'b01:   fifo_cnt_r <= fifo_cnt_r - 2'h1;
				default: fifo_cnt_r <= fifo_cnt_r;
			endcase
		end
	end

	// ------------------------------------------------------------
	// interrupt requests (levels; error flags never raise one)
	// ------------------------------------------------------------
	assign irq_tx_empty    = global_irq_enable && ctrl_r[`USF_CT_UDRIE] && udre;
	assign irq_tx_complete = global_irq_enable && ctrl_r[`USF_CT_TXCIE] && txc_r;
	assign irq_rx_complete = global_irq_enable && ctrl_r[`USF_CT_RXCIE] && rxc;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	sequence s_write_data;
		wr_data;
	endsequence
	sequence s_buf_busy;
		!udre;
	endsequence

	a_data_write_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
		s_write_data |=> s_buf_busy)
		else $error("empty flag still high after data write");
	a_txc_sets_done: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(tx_done && udre) |=> txc_r)
		else $error("complete flag missing after last bit");
	a_txc_ack_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(txc_irq_ack && !(tx_done && udre)) |=> !txc_r)
		else $error("complete flag survived service");
	a_tx_pin_release: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$fell(serial_out_oe) |-> $past(!tx_busy && !ctrl_r[`USF_CT_TRANSMIT_ENABLE_BIT]))
		else $error("pin released with data pending");
	a_rx_flush_empty: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!rx_en |=> !rxc && !irq_rx_complete)
		else $error("buffer not flushed on disable");
	a_rx_push_seen: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(push && !pop && rx_en) |=> ##0 rxc ##1 (rxc || !$past(rx_en) || $past(pop)))
		else $error("received frame not flagged");
	a_overrun_flag: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(ovr_set && rx_en) |=> dor_pend_r)
		else $error("overrun not recorded");
	a_overrun_clear: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(push && !ovr_set && rx_en) |=> !dor_pend_r)
		else $error("overrun survived move");
	a_parity_off_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(rd_go && s_axi_araddr == `USF_OFF_STATUS && !par_en)
		|=> !s_axi_rdata[`USF_ST_PE])
		else $error("parity error shown while disabled");
	a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rst_b)
		fifo_cnt_r <= `USF_FIFO_FULL)
		else $error("fifo count beyond two");

endmodule

// *** usf_remote_xcvr.sv ***
`timescale 1ns/100ps

// ----------------------------------------
// far-end serial transceiver
// ----------------------------------------
module usf_remote_xcvr
(
	input  wire logic       ref_clk,
	input  wire logic       bit_tick,
	input  wire logic       serial_out_pin,
	input  wire logic       serial_out_oe,
	input  wire logic [3:0] cap_len,
	output logic            serial_in_pin
);
	logic [15:0] rx_q[$];   // frames seen, first bit after start in bit 0
	logic [15:0] sh;        // frame being collected
	// a released pin floats to the pull-up, never the last value
	wire         line = serial_out_oe ? serial_out_pin : 1'b1;

	initial serial_in_pin = 1'b1;

	// collect frames: low line at a tick is a start bit
	initial forever
	begin
		@(posedge ref_clk iff (bit_tick && !line));
		sh = 16'h0;
		for (int i = 0; i < cap_len; i++)
		begin
			@(posedge ref_clk iff bit_tick);
			sh[i] = line;
		end
		rx_q.push_back(sh);
	end

	// one frame, lsb first, stop included in bits; one stop only
	task automatic send(input logic [15:0] bits, input int n);
		@(posedge ref_clk iff bit_tick);
		serial_in_pin <= 1'b0;
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk iff bit_tick);
			serial_in_pin <= bits[i];
		end
		@(posedge ref_clk iff bit_tick);
		serial_in_pin <= 1'b1;
	endtask
endmodule

// *** tb_usf_uart_flags.sv ***
`timescale 1ns/100ps
`include "usf_defines.svh"

module tb_usf_uart_flags;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        ref_clk = 1'b0, rst_b = 1'b0, bit_tick = 1'b0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, cap_len = 4'h9;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        global_irq_enable = 1'b0, txc_irq_ack = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r, tick_cnt = 2'h0;
	logic        serial_in_pin, rx_pin_owned, serial_out_pin, serial_out_oe;
	logic        irq_tx_empty, irq_tx_complete, irq_rx_complete;
	logic [8:0]  d, e;                                  // random characters
	logic [7:0]  fm [3] = '{8'h03, 8'h23, 8'h33};       // none, even, odd parity
	int          error_cnt = 0, num_checks = 0;

	usf_uart_flags uut (.ref_clk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bit_tick, .serial_in_pin, .rx_pin_owned,
		.serial_out_pin, .serial_out_oe, .global_irq_enable, .txc_irq_ack, .irq_tx_empty,
		.irq_tx_complete, .irq_rx_complete);

	usf_remote_xcvr peer (.ref_clk, .bit_tick, .serial_out_pin, .serial_out_oe, .cap_len,
		.serial_in_pin);

	// clock, and a bit tick every fourth cycle
	initial forever #25 ref_clk = ~ref_clk;
	always @(posedge ref_clk)
	begin
		tick_cnt <= tick_cnt + 2'h1;
		bit_tick <= (tick_cnt == 2'h3);
	end

	// ----------------------------------------
	// checks, verdict, bus tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// a wait that ran out counts as a mismatch
	task automatic hang();
		error_cnt++;
		$display("CHECK FAILED wait expired");
		end_of_test();
	endtask

	// address and data offered together, each dropped once taken
	task automatic axw(input logic [3:0] a, input logic [31:0] v, output logic [1:0] resp);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			n++;
			if (aw && w && s_axi_bvalid)
				break;
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
			if (n > 60)
				hang();
		end
		resp = s_axi_bresp;
	endtask

	task automatic axr(input logic [3:0] a, output logic [31:0] v);
		int n;
		logic ar;
		n = 0;
		ar = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever
		begin
			@(posedge ref_clk);
			n++;
			if (ar && s_axi_rvalid)
				break;
			ar = ar | s_axi_arready;
			s_axi_arvalid <= !ar;
			if (n > 60)
				hang();
		end
		v = s_axi_rdata;
	endtask

	// poll status until a bit of the mask is set
	task automatic poll(input logic [31:0] m);
		for (int i = 0; i < 300; i++)
		begin
			axr(`USF_OFF_STATUS, rd);
			if ((rd & m) != 32'h0)
				return;
		end
		hang();
	endtask

	// expected parity bit of a byte
	function automatic logic par(input logic [7:0] v, input logic odd);
		return ^v ^ odd;
	endfunction

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		void'($urandom(24));
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		axr(`USF_OFF_STATUS, rd);
		chk("status rst", rd, 32'h20);
		axr(`USF_OFF_FORMAT, rd);
		chk("format rst", rd, 32'h03);
		axw(4'h2, 32'h0, r);
		chk("misaligned", {30'h0, r}, {30'h0, `USF_RESP_SLV});
		global_irq_enable <= 1'b1;
		$display("reset test done");
		// transmit frames in all parity modes
		foreach (fm[i])
		begin
			d = 9'($urandom & 32'hff);
			cap_len <= fm[i][5] ? 4'ha : 4'h9;
			axw(`USF_OFF_FORMAT, {24'h0, fm[i]}, r);
			axw(`USF_OFF_CONTROL, 32'h58, r);
			axw(`USF_OFF_DATA, {23'h0, d}, r);
			poll(32'h40);
			chk("txc irq", {31'h0, irq_tx_complete}, 32'h1);
			chk("tx frame", {16'h0, peer.rx_q.pop_front()}, fm[i][5] ?
				{22'h0, 1'b1, par(d[7:0], fm[i][4]), d[7:0]} : {23'h0, 1'b1, d[7:0]});
			if (i == 0)
				txc_irq_ack <= 1'b1;
			else
				axw(`USF_OFF_STATUS, 32'h40, r);
			@(posedge ref_clk);
			txc_irq_ack <= 1'b0;
			axr(`USF_OFF_STATUS, rd);
			chk("txc clear", rd, 32'h20);
		end
		$display("transmit test done");
		// second write waits in the buffer; disable defers until drained
		cap_len <= 4'h9;
		d = 9'($urandom & 32'hff);
		e = 9'($urandom & 32'hff);
		axw(`USF_OFF_FORMAT, 32'h03, r);
		axw(`USF_OFF_CONTROL, 32'h38, r);
		axw(`USF_OFF_DATA, {23'h0, d}, r);
		axw(`USF_OFF_DATA, {23'h0, e}, r);
		axr(`USF_OFF_STATUS, rd);
		chk("empty flag", rd & 32'h20, 32'h0);
		chk("empty irq", {31'h0, irq_tx_empty}, 32'h0);
		axw(`USF_OFF_CONTROL, 32'h30, r);
		chk("oe held", {31'h0, serial_out_oe}, 32'h1);
		poll(32'h40);
		repeat (2) @(posedge ref_clk);
		chk("oe released", {31'h0, serial_out_oe}, 32'h0);
		chk("frame 1", {16'h0, peer.rx_q.pop_front()}, {24'h1, d[7:0]});
		chk("frame 2", {16'h0, peer.rx_q.pop_front()}, {24'h1, e[7:0]});
		chk("empty irq", {31'h0, irq_tx_empty}, 32'h1);
		global_irq_enable <= 1'b0;
		@(posedge ref_clk);
		chk("empty irq gated", {31'h0, irq_tx_empty}, 32'h0);
		global_irq_enable <= 1'b1;
		axw(`USF_OFF_STATUS, 32'h40, r);
		$display("disable test done");
		// receive one good frame, then one with bad parity and bad stop
		axw(`USF_OFF_FORMAT, 32'h23, r);
		axw(`USF_OFF_CONTROL, 32'h90, r);
		chk("pin owned", {31'h0, rx_pin_owned}, 32'h1);
		peer.send({6'h0, 1'b1, par(d[7:0], 1'b0), d[7:0]}, 10);
		peer.send({6'h0, 1'b0, ~par(e[7:0], 1'b0), e[7:0]}, 10);
		axr(`USF_OFF_STATUS, rd);
		chk("rx status 1", rd, 32'ha0);
		chk("rx irq", {31'h0, irq_rx_complete}, 32'h1);
		axr(`USF_OFF_DATA, rd);
		chk("rx data 1", rd, {24'h0, d[7:0]});
		axw(`USF_OFF_STATUS, 32'h0, r);
		axr(`USF_OFF_STATUS, rd);
		chk("rx status 2", rd, 32'hb4);
		axr(`USF_OFF_DATA, rd);
		chk("rx data 2", rd, {24'h0, e[7:0]});
		axr(`USF_OFF_STATUS, rd);
		chk("rx drained", rd, 32'h20);
		chk("rx irq off", {31'h0, irq_rx_complete}, 32'h0);
		// two buffered, one held; a fourth start loses the held one
		axw(`USF_OFF_FORMAT, 32'h03, r);
		for (int k = 0; k < 4; k++)
			peer.send({8'h1, k[0] ? e[7:0] : d[7:0]}, 9);
		axr(`USF_OFF_DATA, rd);
		chk("ovr data 1", rd, {24'h0, d[7:0]});
		axr(`USF_OFF_DATA, rd);
		chk("ovr data 2", rd, {24'h0, e[7:0]});
		axr(`USF_OFF_STATUS, rd);
		chk("ovr status", rd, 32'ha8);
		axr(`USF_OFF_DATA, rd);
		chk("ovr data 4", rd, {24'h0, e[7:0]});
		peer.send({8'h1, d[7:0]}, 9);
		poll(32'h80);
		axr(`USF_OFF_STATUS, rd);
		chk("ovr cleared", rd, 32'ha0);
		axr(`USF_OFF_DATA, rd);
		chk("ovr data 5", rd, {24'h0, d[7:0]});
		// five-bit and nine-bit characters
		axw(`USF_OFF_FORMAT, 32'h00, r);
		peer.send({11'h1, d[4:0]}, 6);
		poll(32'h80);
		axr(`USF_OFF_DATA, rd);
		chk("short char", rd, {27'h0, d[4:0]});
		e = 9'($urandom & 32'h1ff);
		axw(`USF_OFF_FORMAT, {29'h0, `USF_SIZE_9BIT}, r);
		peer.send({7'h1, e}, 10);
		poll(32'h80);
		axr(`USF_OFF_CONTROL, rd);
		chk("ninth bit", rd, {24'h0, 6'h24, e[8], 1'b0});
		axr(`USF_OFF_DATA, rd);
		chk("nine low", rd, {24'h0, e[7:0]});
		// disabling the receiver empties the buffer
		peer.send({7'h1, d}, 10);
		poll(32'h80);
		axw(`USF_OFF_CONTROL, 32'h00, r);
		axr(`USF_OFF_STATUS, rd);
		chk("flushed", rd, 32'h20);
		chk("pin free", {31'h0, rx_pin_owned}, 32'h0);
		$display("receive test done");
		end_of_test();
	end
endmodule
